//--- memmap_defs.vh
// Address map constants for the CPU memory map decoder.
// Assumes a 20-bit byte address from the CPU core.
`ifndef MEMMAP_DEFS_VH
`define MEMMAP_DEFS_VH
`define ADDR_W          20
`define TOP_NIBBLE_LO   4'h0
`define TOP_NIBBLE_HI   4'hf
`define DATA_LO_START   16'hee00
`define SFR_LO_START    16'hff00
`define RAM_FAST_START  16'hfd00
`define ROM_LAST        20'h1ffff
`define VEC_LAST        20'h0003f
`define TBL_FIRST       20'h00040
`define TBL_LAST        20'h0007f
`define FIX_FIRST       20'h00800
`define FIX_LAST        20'h00fff
`define BASE_TOP_ZERO   4'h0
`define RESET_VEC_ADDR  20'h00000
`define VEC_NMI         20'h00002
`define VEC_WDT_NMI     20'h00004
`define VEC_WDT_MASK    20'h00006
`define VEC_PIN0        20'h00008
`define VEC_PIN_LAST    20'h00012
`define VEC_OPERR       20'h0003c
`define VEC_BREAK       20'h0003e
`define TBL_IDX_W       5
`define FIX_OFS_W       11
`define FAST_FETCH_CYC  2'h2
`endif

//--- cpu_memory_map_decoder.v
// Memory map decoder and fetch-path selector for a 1 MB CPU space.
// Assumes the CPU core presents one access at a time, synchronous to mclk.
//
// Behaviour
// - Decode full 20-bit one-megabyte space.
// - Placement accepted once after reset only.
// - Data area at 0EE00-0FFFF or FEE00-FFFFF.
// - Data area wins over overlapping regions.
// - Hidden ROM usable only with high placement.
// - Fast fetch: two bytes per two clocks.
// - Reset selects slow external-like fetch; here rom_fast_fetch_bit is a plain input with no reset value.
// - Fast fetch on ROM: one wait, no external waits.
// - Vector region 00000-0003F holds entry words.
// - Vector entries are 16-bit, base-area targets.
// - Fixed vector addresses per interrupt source.
// - Table call reads one of 32 entries.
// - Fixed call targets only 00800-00FFF.
// - No fetch from fast RAM or registers.
// - Unmapped goes external only in expansion mode.
// - Internal RAM never serves reset entry.
// - Reset loads PC low word, top nibble zero.
// - Special registers take top 256 bytes.
`timescale 1ns/10ps
`default_nettype none
`include "memmap_defs.vh"

module cpu_memory_map_decoder (
  input  wire        mclk,
  input  wire        rst,
  input  wire        place_req,
  input  wire        place_high,
  input  wire        acc_valid,
  input  wire        acc_fetch,
  input  wire [19:0] acc_addr,
  input  wire        rom_fast_fetch_bit,
  input  wire        ext_expansion_en,
  input  wire        ext_wait_req,
  input  wire        vec_req,
  input  wire [5:0]  vec_sel,
  input  wire        tbl_req,
  input  wire [4:0]  tbl_idx,
  input  wire        fix_req,
  input  wire [10:0] fix_ofs,
  input  wire [15:0] reset_word,
  output reg         placed_ff,
  output reg         high_ff,
  output reg         sel_rom_ff,
  output reg         sel_ram_ff,
  output reg         sel_sfr_ff,
  output reg         sel_ext_ff,
  output reg         fetch_fault_ff,
  output reg         unmapped_ff,
  output reg  [1:0]  fetch_bytes_ff,
  output wire        acc_wait,
  output reg  [19:0] vec_addr_ff,
  output reg  [19:0] tbl_addr_ff,
  output reg  [19:0] fix_addr_ff,
  output reg  [19:0] reset_pc_ff,
  output reg         reset_pc_vld_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Placement lock
  wire do_place = place_req & ~placed_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      placed_ff <= 1'b0;
      high_ff   <= 1'b0;
    end else if (do_place) begin
      placed_ff <= 1'b1;
      high_ff   <= place_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Region decode
  wire [3:0]  top_nib = acc_addr[19:16];
  wire [15:0] low16   = acc_addr[15:0];
  wire [3:0]  data_nib = high_ff ? `TOP_NIBBLE_HI : `TOP_NIBBLE_LO;
  // Before placement the low map is assumed; software places first anyway.
  wire in_data = (top_nib == data_nib) & (low16 >= `DATA_LO_START);
  wire in_sfr  = in_data & (low16 >= `SFR_LO_START);
  wire in_fast = in_data & ~in_sfr & (low16 >= `RAM_FAST_START);
  wire in_rom  = (acc_addr <= `ROM_LAST) & ~in_data;
  wire in_ext  = ~in_data & ~in_rom;

  reg nxt_rom;
  reg nxt_ram;
  reg nxt_sfr;
  reg nxt_ext;
  reg nxt_fault;
  reg nxt_unmapped;

  always @* begin
    nxt_rom      = 1'b0;
    nxt_ram      = 1'b0;
    nxt_sfr      = 1'b0;
    nxt_ext      = 1'b0;
    nxt_fault    = 1'b0;
    nxt_unmapped = 1'b0;
    if (acc_valid) begin
      if (in_data) begin
        if (acc_fetch & (in_sfr | in_fast)) begin
          nxt_fault = 1'b1;
        end else if (in_sfr) begin
          nxt_sfr = 1'b1;
        end else begin
          nxt_ram = 1'b1;
        end
      end else if (in_rom) begin
        nxt_rom = 1'b1;
      end else if (in_ext & ext_expansion_en) begin
        nxt_ext = 1'b1;
      end else begin
        nxt_unmapped = 1'b1;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_rom_ff     <= 1'b0;
      sel_ram_ff     <= 1'b0;
      sel_sfr_ff     <= 1'b0;
      sel_ext_ff     <= 1'b0;
      fetch_fault_ff <= 1'b0;
      unmapped_ff    <= 1'b0;
      fetch_bytes_ff <= 2'h0;
    end else begin
      sel_rom_ff     <= nxt_rom;
      sel_ram_ff     <= nxt_ram;
      sel_sfr_ff     <= nxt_sfr;
      sel_ext_ff     <= nxt_ext;
      fetch_fault_ff <= nxt_fault;
      unmapped_ff    <= nxt_unmapped;
      // Fast ROM fetch delivers a 2-byte word per access
      if (nxt_rom & acc_fetch & rom_fast_fetch_bit) begin
        fetch_bytes_ff <= `FAST_FETCH_CYC;
      end else if (nxt_rom & acc_fetch) begin
        fetch_bytes_ff <= 2'h1;
      end else begin
        fetch_bytes_ff <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch timing: fast fetch holds one wait cycle so a word takes two clocks
  reg fast_busy_ff;
  wire fast_start = nxt_rom & acc_fetch & rom_fast_fetch_bit & ~fast_busy_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fast_busy_ff <= 1'b0;
    end else begin
      fast_busy_ff <= fast_start;
    end
  end

  // External waits never reach a fast ROM access; in slow mode they may.
  // Waits on ROM in slow mode are software's responsibility to avoid.
  assign acc_wait = fast_start |
                    (acc_valid & ~(in_rom & rom_fast_fetch_bit) &
                     ext_wait_req & ~in_data);

  ////////////////////////////////////////////////////////////////////////////
  // Vector, table-call and fixed-call address generation
  reg [19:0] nxt_vec;

  always @* begin
    nxt_vec = vec_addr_ff;
    if (vec_req) begin
      nxt_vec = {14'h0000, vec_sel[5:1], 1'b0};
      if (vec_sel == 6'h00) begin
        nxt_vec = `VEC_NMI;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      vec_addr_ff <= `RESET_VEC_ADDR;
      tbl_addr_ff <= `TBL_FIRST;
      fix_addr_ff <= `FIX_FIRST;
    end else begin
      vec_addr_ff <= nxt_vec;
      if (tbl_req) begin
        tbl_addr_ff <= `TBL_FIRST | {14'h0000, tbl_idx, 1'b0};
      end
      if (fix_req) begin
        fix_addr_ff <= `FIX_FIRST | {9'h000, fix_ofs};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset program counter: word from ROM at 0/1, never internal RAM
  reg first_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      first_ff        <= 1'b1;
      reset_pc_ff     <= 20'h00000;
      reset_pc_vld_ff <= 1'b0;
    end else if (first_ff) begin
      first_ff        <= 1'b0;
      reset_pc_ff     <= {`BASE_TOP_ZERO, reset_word};
      reset_pc_vld_ff <= 1'b1;
    end else begin
      reset_pc_vld_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- mm_decoder_properties.sv
// Checker for the memory map decoder, bound to its top ports.
// Assumes one access per cycle and the low map until placement.
`timescale 1ns/10ps
`default_nettype none
module mm_decoder_chk (
  input wire logic        mclk, rst, place_req, place_high,
  input wire logic        acc_valid, acc_fetch, rom_fast_fetch_bit,
  input wire logic        ext_expansion_en, placed_ff, high_ff,
  input wire logic        sel_rom_ff, sel_ram_ff, sel_sfr_ff, sel_ext_ff,
  input wire logic        fetch_fault_ff, unmapped_ff,
  input wire logic [19:0] acc_addr,
  input wire logic [1:0]  fetch_bytes_ff,
  input wire logic        acc_wait
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Same-edge placement may still see the old map
  wire logic lo = !high_ff && !place_req;
  wire logic rf = acc_valid && acc_fetch && acc_addr < 20'h0ee00;
  wire logic rd = acc_valid && !acc_fetch && lo;
  property p_lk; placed_ff |=> placed_ff && $stable(high_ff); endproperty
  a_lk: assert property (p_lk) else $error("lock lost");
  property p_tk;
    place_req && !placed_ff |=> placed_ff && high_ff == $past(place_high);
  endproperty
  a_tk: assert property (p_tk) else $error("place");
  property p_fa; rf && rom_fast_fetch_bit |=> fetch_bytes_ff == 2'h2;
  endproperty
  a_fa: assert property (p_fa) else $error("fast");
  property p_sl; rf && !rom_fast_fetch_bit |=> fetch_bytes_ff == 2'h1;
  endproperty
  a_sl: assert property (p_sl) else $error("slow");
  property p_ft;
    acc_valid && acc_fetch && lo && acc_addr >= 20'h0fd00
      && acc_addr <= 20'h0ffff |=> fetch_fault_ff && !sel_sfr_ff;
  endproperty
  a_ft: assert property (p_ft) else $error("fault");
  property p_sf; rd && acc_addr[19:8] == 12'h0ff |=> sel_sfr_ff;
  endproperty
  a_sf: assert property (p_sf) else $error("sfr");
  property p_rm;
    rd && acc_addr >= 20'h0ee00 && acc_addr < 20'h0ff00
      |=> sel_ram_ff && !sel_rom_ff;
  endproperty
  a_rm: assert property (p_rm) else $error("ram");
  property p_ex; acc_valid && acc_addr[19:17] == 3'h3
    |=> ($past(ext_expansion_en) ? sel_ext_ff : unmapped_ff);
  endproperty
  a_ex: assert property (p_ex) else $error("ext");
  // Fast ROM word after an idle cycle: wait asserted on its first cycle
  property p_wt;
    rf && rom_fast_fetch_bit && !$past(acc_valid) |-> acc_wait;
  endproperty
  a_wt: assert property (p_wt) else $error("fast wait");
  cover property (place_req && !placed_ff);
  cover property (rf && rom_fast_fetch_bit);
  cover property (fetch_fault_ff);
endmodule
bind cpu_memory_map_decoder mm_decoder_chk i_mm_decoder_chk (.*);
`default_nettype wire

//--- cpu_core_model.sv
// CPU core model: placement requests, fetches and data accesses.
// Assumes the decoder samples on rising mclk.
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input  wire logic        mclk,
  output var  logic        place_req, place_high, acc_valid, acc_fetch,
  output var  logic [19:0] acc_addr
);
  initial {place_req, place_high, acc_valid, acc_fetch, acc_addr} = '0;
  task automatic acc(input logic [19:0] a, input logic f);
    @(negedge mclk) {acc_valid, acc_fetch, acc_addr} = {1'b1, f, a};
    // Idle bus shows no stale address
    @(negedge mclk) {acc_valid, acc_addr} = {1'b0, ~a};
  endtask
  task automatic place(input logic h);
    @(negedge mclk) {place_req, place_high} = {1'b1, h};
    @(negedge mclk) place_req = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the memory map decoder.
// Assumes outputs settle by the falling edge after an access.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk = 0, rst = 1, fast = 0, ext = 0, vr = 0, tr = 0, fr = 0;
  logic [5:0] vs = 0;
  logic [4:0] ti = 0;
  logic [10:0] fo = 0;
  wire logic pr, ph, av, af, pl, hi, vld;
  wire logic [19:0] aa, va, ta, fa, pc;
  wire logic [5:0] sel;
  wire logic [1:0] fb;
  int mismatches = 0, total_checks = 0, cyc = 0;
  always #4 mclk = ~mclk;
  cpu_core_model i_cpu_core_model (.mclk, .place_req(pr), .place_high(ph),
    .acc_valid(av), .acc_fetch(af), .acc_addr(aa));
  // No external waits on internal ROM: that would lock the core
  cpu_memory_map_decoder i_cpu_memory_map_decoder (.mclk, .rst,
    .place_req(pr), .place_high(ph), .acc_valid(av), .acc_fetch(af),
    .acc_addr(aa), .rom_fast_fetch_bit(fast), .ext_expansion_en(ext),
    .ext_wait_req(1'b0), .vec_req(vr), .vec_sel(vs), .tbl_req(tr),
    .tbl_idx(ti), .fix_req(fr), .fix_ofs(fo), .reset_word(16'hbeef),
    .placed_ff(pl), .high_ff(hi), .sel_rom_ff(sel[5]), .sel_ram_ff(sel[4]),
    .sel_sfr_ff(sel[3]), .sel_ext_ff(sel[2]), .fetch_fault_ff(sel[1]),
    .unmapped_ff(sel[0]), .fetch_bytes_ff(fb), .acc_wait(),
    .vec_addr_ff(va), .tbl_addr_ff(ta), .fix_addr_ff(fa),
    .reset_pc_ff(pc), .reset_pc_vld_ff(vld));
  task chk(input string n, input logic [19:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task probe(input logic [19:0] a, input logic f, input logic [5:0] e);
    i_cpu_core_model.acc(a, f);
    chk("sel", {14'h0, sel}, {14'h0, e});
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict;
    end
  end
  task t_low;
    chk("pc", pc, 20'h0beef);
    chk("vld", {19'h0, vld}, 20'h1);
    chk("tbl", ta, 20'h00040);
    probe(20'h00000, 1, 6'h20);
    chk("bytes", {18'h0, fb}, 20'h1);
    probe(20'h0ee00, 0, 6'h10);
    probe(20'h0fd00, 1, 6'h02);
    probe(20'h0ffff, 0, 6'h08);
    probe(20'h60000, 0, 6'h01);
    ext = 1;
    probe(20'h60000, 1, 6'h04);
    $display("low map done");
  endtask
  task t_place;
    i_cpu_core_model.place(1);
    chk("lock", {18'h0, pl, hi}, 20'h3);
    i_cpu_core_model.place(0);
    chk("keep", {18'h0, pl, hi}, 20'h3);
    probe(20'h0ee00, 1, 6'h20);
    probe(20'h1ffff, 0, 6'h20);
    probe(20'hfee00, 0, 6'h10);
    probe(20'hffd00, 1, 6'h02);
    fast = 1;
    probe(20'h00100, 1, 6'h20);
    chk("bytes", {18'h0, fb}, 20'h2);
    $display("high map done");
  endtask
  task t_calls;
    {vr, tr, fr, vs, ti, fo} = {3'h7, 6'h3e, 5'h1f, 11'h7ff};
    @(negedge mclk) {vr, tr, fr} = 3'h0;
    chk("vec", va, 20'h0003e);
    chk("tbl", ta, 20'h0007e);
    chk("fix", fa, 20'h00fff);
    $display("calls done");
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 0;
    @(negedge mclk);
    t_low;
    t_place;
    t_calls;
    give_verdict;
  end
endmodule
`default_nettype wire
